// File: core/adc_mon_defines.svh
`ifndef ADC_MON_DEFINES_SVH
`define ADC_MON_DEFINES_SVH

`define OFS_LOW_TH_LO   8'ha5
`define OFS_LOW_TH_HI   8'ha6
`define OFS_HIGH_TH_LO  8'haa
`define OFS_HIGH_TH_HI  8'hab
`define OFS_STAT_FILT   8'hac
`define OFS_VREF_TRIM   8'hc8
`define OFS_VREF_4V096  8'hcc
`define OFS_VREF_1V024  8'hcd
`define OFS_VREF_2V048  8'hce
`define OFS_MON_CTRL    8'hb8
`define OFS_IRQ_STATUS  8'hb9
`define OFS_IRQ_CLEAR   8'hba
`define OFS_IRQ_ENABLE  8'hbb

`define DIR_BIT         7
`define ENABLE_BIT      4
`define LEVEL_LSB       5
`define FILT_RESET      4'h1
`define IRQ_OVER_BIT    0
`define IRQ_UNDER_BIT   1

`endif

// File: core/adc_mon_pkg.sv
package adc_mon_pkg;

  typedef enum logic [1:0] {
    CAND_NONE,
    CAND_UNDER,
    CAND_OVER
  } cand_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } reg_req_t;

  typedef struct packed {
    logic [7:0]  low_lo;
    logic [7:0]  low_hi;
    logic [7:0]  high_lo;
    logic [7:0]  high_hi;
    logic [3:0]  filt;
    logic        dir;
    logic [7:0]  trim;
    logic        enable;
    logic [1:0]  level;
    logic [3:0]  count;
    cand_t       last;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_en;
    logic        event_p;
    logic [7:0]  rdata;
  } mon_state_t;

endpackage : adc_mon_pkg

// File: core/adc_auto_monitor.sv
`timescale 1ns/1ps
`include "adc_mon_defines.svh"

// Overview of operation
// - On each monitor event bit 7 of the status register shows 1 for overflow and 0 for underflow.
// - Filter value 0 turns monitoring off and 1 raises an event on a single result.
// - Filter values 2 to 15 raise an event only after that many consecutive agreeing results.
// - The lower threshold is two writable bytes at 0xa5 and 0xa6, reset to zero.
// - The upper threshold is two writable bytes at 0xaa and 0xab, reset to zero.
// - After reset the active trim register at 0xc8 holds the 1.024V factor.
// - The three factors at 0xcd, 0xce and 0xcc are read-only and writes to them are ignored.
// - Monitoring runs only while the monitor enable bit is one.
// - Level code 00 picks 1.024V, 01 picks 2.048V and 1x picks 4.096V.
module adc_auto_monitor
  import adc_mon_pkg::*;
#(
  parameter logic [7:0] FACTOR_1V024 = 8'h80, // Arbitrary default, set per die
  parameter logic [7:0] FACTOR_2V048 = 8'h80, // Arbitrary default, set per die
  parameter logic [7:0] FACTOR_4V096 = 8'h80, // Arbitrary default, set per die
  parameter int         RESULT_W     = 16
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  input  wire logic                result_valid,
  input  wire logic [RESULT_W-1:0] result_data,
  output logic                     monitor_event,
  output logic                     monitor_direction_flag,
  output logic      [7:0]          active_vref_trim,
  output logic      [7:0]          selected_factor,
  output logic      [1:0]          internal_ref_level_select,
  output logic                     irq
);

  // Comparator is 16 bits wide, so wider results cannot be served
  if (RESULT_W < 1 || RESULT_W > 16) begin : g_bad_width
    $error("RESULT_W must be 1 to 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  mon_state_t st_r;
  mon_state_t st_nxt;
  reg_req_t   req;
  logic [15:0] low_th;
  logic [15:0] high_th;
  logic [15:0] result16;
  cand_t       cand;
  logic        fire;

  assign req      = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
  assign low_th   = {st_r.low_hi, st_r.low_lo};
  assign high_th  = {st_r.high_hi, st_r.high_lo};
  assign result16 = 16'(result_data);

  function automatic logic [7:0] factor_for(input logic [1:0] lvl);
    logic [7:0] f;
    f = FACTOR_1V024;
    unique case (lvl)
      2'b00: f = FACTOR_1V024;
      2'b01: f = FACTOR_2V048;
      default: f = FACTOR_4V096;
    endcase
    return f;
  endfunction : factor_for

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    if (result16 > high_th) begin
      cand = CAND_OVER;
    end else if (result16 < low_th) begin
      cand = CAND_UNDER;
    end else begin
      cand = CAND_NONE;
    end
  end

  always_comb begin
    st_nxt         = st_r;
    st_nxt.event_p = 1'b0;
    fire           = 1'b0;

    // Monitoring stage; a new result is needed before any counting
    if (!st_r.enable || st_r.filt == 4'h0) begin
      st_nxt.count = 4'h0;
      st_nxt.last  = CAND_NONE;
    end else if (result_valid) begin
      if (cand == CAND_NONE) begin
        st_nxt.count = 4'h0;
        st_nxt.last  = CAND_NONE;
      end else begin
        // Opposite kind restarts at one rather than zero
        if (cand != st_r.last || st_r.count == 4'h0) begin
          st_nxt.count = 4'h1;
        end else if (st_r.count != 4'hf) begin
          st_nxt.count = st_r.count + 4'h1;
        end
        st_nxt.last = cand;
        if (st_nxt.count >= st_r.filt) begin
          fire         = 1'b1;
          st_nxt.count = 4'h0;  // Count starts over after each event
          st_nxt.last  = CAND_NONE;
        end
      end
    end

    if (fire) begin
      st_nxt.dir     = (cand == CAND_OVER);
      st_nxt.event_p = 1'b1;
    end

    // Register writes
    if (req.wr) begin
      unique case (req.addr)
        `OFS_LOW_TH_LO:  st_nxt.low_lo  = req.wdata;
        `OFS_LOW_TH_HI:  st_nxt.low_hi  = req.wdata;
        `OFS_HIGH_TH_LO: st_nxt.high_lo = req.wdata;
        `OFS_HIGH_TH_HI: st_nxt.high_hi = req.wdata;
        `OFS_STAT_FILT:  st_nxt.filt    = req.wdata[3:0];
        `OFS_VREF_TRIM:  st_nxt.trim    = req.wdata;
        `OFS_MON_CTRL: begin
          st_nxt.enable = req.wdata[`ENABLE_BIT];
          st_nxt.level  = req.wdata[`LEVEL_LSB +: 2];
        end
        `OFS_IRQ_CLEAR:  st_nxt.irq_stat = st_r.irq_stat & ~req.wdata[1:0];
        `OFS_IRQ_ENABLE: st_nxt.irq_en   = req.wdata[1:0];
        default: ;  // Factor registers ignore writes
      endcase
    end

    // Set wins over a same-cycle clear
    if (fire) begin
      if (cand == CAND_OVER) begin
        st_nxt.irq_stat[`IRQ_OVER_BIT] = 1'b1;
      end else begin
        st_nxt.irq_stat[`IRQ_UNDER_BIT] = 1'b1;
      end
    end

    // Read data for the cycle after the strobe
    st_nxt.rdata = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        `OFS_LOW_TH_LO:  st_nxt.rdata = st_r.low_lo;
        `OFS_LOW_TH_HI:  st_nxt.rdata = st_r.low_hi;
        `OFS_HIGH_TH_LO: st_nxt.rdata = st_r.high_lo;
        `OFS_HIGH_TH_HI: st_nxt.rdata = st_r.high_hi;
        `OFS_STAT_FILT:  st_nxt.rdata = {st_r.dir, 3'h0, st_r.filt};
        `OFS_VREF_TRIM:  st_nxt.rdata = st_r.trim;
        `OFS_VREF_4V096: st_nxt.rdata = FACTOR_4V096;
        `OFS_VREF_1V024: st_nxt.rdata = FACTOR_1V024;
        `OFS_VREF_2V048: st_nxt.rdata = FACTOR_2V048;
        `OFS_MON_CTRL:   st_nxt.rdata = {1'b0, st_r.level, st_r.enable, 4'h0};
        `OFS_IRQ_STATUS: st_nxt.rdata = {6'h00, st_r.irq_stat};
        `OFS_IRQ_ENABLE: st_nxt.rdata = {6'h00, st_r.irq_en};
        default:         st_nxt.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st_r          <= '0;
      st_r.filt     <= `FILT_RESET;
      st_r.trim     <= FACTOR_1V024;
      st_r.last     <= CAND_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata                 = st_r.rdata;
  assign monitor_event             = st_r.event_p;
  assign monitor_direction_flag    = st_r.dir;
  assign active_vref_trim          = st_r.trim;
  assign internal_ref_level_select = st_r.level;
  assign selected_factor           = factor_for(st_r.level);
  assign irq                       = |(st_r.irq_stat & st_r.irq_en);

endmodule : adc_auto_monitor

// File: sim/adc_mon_asserts.sv
`timescale 1ns/1ps
module adc_mon_asserts #(
  parameter int         RESULT_W = 16,
  parameter logic [7:0] F1       = 8'h80,
  parameter logic [7:0] F2       = 8'h80,
  parameter logic [7:0] F4       = 8'h80
) (
  input wire logic                ref_clk,
  input wire logic                rst_b,
  input wire logic [7:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [7:0]          reg_rdata,
  input wire logic                result_valid,
  input wire logic [RESULT_W-1:0] result_data,
  input wire logic                monitor_event,
  input wire logic                monitor_direction_flag,
  input wire logic [7:0]          active_vref_trim,
  input wire logic [7:0]          selected_factor,
  input wire logic [1:0]          internal_ref_level_select,
  input wire logic                irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_trim_wr;
    reg_wr && reg_addr == 8'hc8;
  endsequence
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero");
  a_trim_write_load: assert property (s_trim_wr |=> active_vref_trim == $past(reg_wdata))
    else $error("trim not loaded");
  a_trim_hold_other: assert property (!s_trim_wr |=> $stable(active_vref_trim))
    else $error("trim changed");
  a_trim_read_back: assert property (reg_rd && reg_addr == 8'hc8 |=> reg_rdata == $past(active_vref_trim))
    else $error("trim read wrong");
  a_factor_by_level: assert property (selected_factor == (internal_ref_level_select[1] ? F4 :
    internal_ref_level_select[0] ? F2 : F1)) else $error("wrong factor");
  a_event_from_result: assert property (monitor_event |-> $past(result_valid))
    else $error("event without result");
  a_dir_only_event: assert property (!monitor_event |-> $stable(monitor_direction_flag))
    else $error("direction moved");
  a_status_dir_read: assert property (reg_rd && reg_addr == 8'hac |=> reg_rdata[7] == $past(monitor_direction_flag))
    else $error("status direction wrong");
endmodule : adc_mon_asserts

bind adc_auto_monitor adc_mon_asserts #(.RESULT_W(RESULT_W), .F1(FACTOR_1V024), .F2(FACTOR_2V048),
  .F4(FACTOR_4V096)) i_adc_mon_asserts (.*);

// File: sim/adc_core_model.sv
`timescale 1ns/1ps
module adc_core_model (
  input  wire logic        ref_clk,
  input  wire logic        start,
  input  wire logic [3:0]  wait_cyc,
  input  wire logic [15:0] sample,
  output logic             result_valid = 1'b0,
  output logic      [15:0] result_data = 16'h0000
);
  logic [3:0] cnt = 4'h0;
  logic       busy = 1'b0;
  always @(posedge ref_clk) begin
    result_valid <= 1'b0;
    // Stale data flips so it is never taken for a result
    result_data <= ~result_data;
    if (start) begin
      busy <= 1'b1;
      cnt <= wait_cyc;
    end else if (busy && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (busy) begin
      busy <= 1'b0;
      result_valid <= 1'b1;
      result_data <= sample;
    end
  end
endmodule : adc_core_model

// File: sim/adc_auto_monitor_tb.sv
`timescale 1ns/1ps
module adc_auto_monitor_tb;
  logic ref_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, start = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, active_vref_trim, selected_factor;
  logic [15:0] sample = 16'h0000, result_data;
  logic [3:0] wait_cyc = 4'h0;
  logic [1:0] internal_ref_level_select;
  logic result_valid, monitor_event, monitor_direction_flag, irq;
  int miscompares = 0, tests_run = 0, events = 0;
  logic [7:0] adr [10] = '{8'ha5, 8'ha6, 8'haa, 8'hab, 8'hac, 8'hc8, 8'hcc, 8'hcd, 8'hce, 8'hb0};
  logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h11, 8'h44, 8'h11, 8'h22, 8'h00};
  logic [7:0] wv [10] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'hff, 8'h44, 8'h11, 8'h22, 8'h00};
  logic [7:0] fv [4] = '{8'h11, 8'h22, 8'h44, 8'h44};
  adc_auto_monitor #(.FACTOR_1V024(8'h11), .FACTOR_2V048(8'h22), .FACTOR_4V096(8'h44)) i_adc_auto_monitor (.*);
  adc_core_model i_adc_core_model (.*);
  initial forever #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (monitor_event === 1'b1) events <= events + 1;
  ////////////////////////////////////////////////////////////
  task stop_test;
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge ref_clk) reg_wr <= 1'b0;
    #1;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk) reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, e);
  endtask : rd
  task conv(input logic [15:0] v);
    int i;
    @(posedge ref_clk) {start, sample} <= {1'b1, v};
    @(posedge ref_clk) start <= 1'b0;
    for (i = 0; i < 20 && result_valid !== 1'b1; i++) @(posedge ref_clk);
    if (i == 20) begin
      miscompares++;
      stop_test();
    end
    // Event lands one edge later, counter one more
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : conv
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int k = 0; k < 10; k++) rd(adr[k], rv[k]);
    for (int k = 0; k < 10; k++) wr(adr[k], 8'hff);
    for (int k = 0; k < 10; k++) rd(adr[k], wv[k]);
    wr(8'hc8, 8'h22);
    chk("trim", active_vref_trim, 8'h22);
    for (int k = 0; k < 4; k++) begin
      wr(8'hb8, 8'h10 | 8'(k << 5));
      chk("factor", selected_factor, fv[k]);
      chk("level", internal_ref_level_select, 16'(k));
    end
    wr(8'ha5, 8'h00);
    wr(8'ha6, 8'h01);
    wr(8'haa, 8'h00);
    wr(8'hab, 8'h02);
    wr(8'hbb, 8'h03);
    wr(8'hac, 8'h03);
    wait_cyc <= 4'h3;
    conv(16'h0300);
    conv(16'h0300);
    conv(16'h0050);
    conv(16'h0300);
    conv(16'h0300);
    chk("events", 16'(events), 16'h0000);
    conv(16'h0300);
    chk("events", 16'(events), 16'h0001);
    rd(8'hac, 8'h83);
    chk("dir", monitor_direction_flag, 1'b1);
    chk("irq", irq, 1'b1);
    wr(8'hba, 8'h01);
    chk("irq", irq, 1'b0);
    wr(8'hac, 8'h01);
    wait_cyc <= 4'h0;
    conv(16'h0050);
    rd(8'hac, 8'h01);
    chk("dir", monitor_direction_flag, 1'b0);
    wr(8'hbb, 8'h01);
    rd(8'hb9, 8'h02);
    chk("irq", irq, 1'b0);
    wr(8'hac, 8'h00);
    conv(16'h0300);
    wr(8'hac, 8'h01);
    wr(8'hb8, 8'h00);
    conv(16'h0300);
    chk("events", 16'(events), 16'h0002);
    // Reset again mid-run, after trim and status have moved
    @(posedge ref_clk) rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(8'hc8, 8'h11);
    rd(8'hac, 8'h01);
    chk("irq", irq, 1'b0);
    stop_test();
  end
endmodule : adc_auto_monitor_tb
